//--- core/shrp_defines.vh
`ifndef SHRP_DEFINES_VH
`define SHRP_DEFINES_VH

// ==========================================================
// Byte and command/address layout
`define SHRP_BYTE_W 8
`define SHRP_ADDR_W 6
`define SHRP_RW_BIT 7
`define SHRP_ADDR_MSB 5
`define SHRP_RW_READ 1'b1

// ==========================================================
// Load control register
`define SHRP_CTL_ADDR 6'h3f
`define SHRP_CTL_RESET 8'h00
`define SHRP_CTL_BOOT_BIT 2
`define SHRP_CTL_MODE_MSB 3
`define SHRP_CTL_MODE_LSB 2
`define SHRP_CTL_MODE_ROM 2'h0
`define SHRP_RD_SIG_SEL_BIT 5
`define SHRP_SIG_SEED 8'h00

// ==========================================================
// Boot program RAM and device registers
`define SHRP_BOOT_DEPTH 4096
`define SHRP_BOOT_AW 12
`define SHRP_DEVICE_REGISTER_DEPTH 64

// ==========================================================
// Pin synchroniser reset levels: {recv, shared, cs_n, sclk}
`define SHRP_PIN_INIT 4'he

`endif

//--- core/shrp_port.v
// Operation
// - SCLK high at select: LSB-first, shared pin bidirectional
// - SCLK low at select: MSB-first, separate receive pin
// - Receive-only pin ignored during the data byte of MSB reads
// - Every transfer: command byte, then data byte
// - First eight clocks carry the command byte
// - Next eight clocks carry data, chosen direction
// - Command byte decodes read/write and address
// - Shared pin released while select is high
// - Data bit order follows the detected mode
// - Command byte fields same in both modes, only bit order per mode
// - Sample on rising, change on falling edge
// - Registers read/write, boot RAM write only
// - Boot writes advance RAM pointer except 3fh
`timescale 1ns/1ns
`include "shrp_defines.vh"

module shrp_port #(
  parameter DEPTH = `SHRP_BOOT_DEPTH,
  parameter AW = `SHRP_BOOT_AW
) (
  // Clock, reset, enable
  input wire core_clk,
  input wire resetn,
  input wire ce,
  // Serial pins
  input wire sclk,
  input wire cs_n,
  input wire shared_tx_rx_pin_in,
  output reg shared_tx_rx_pin_out_q,
  output reg shared_tx_rx_pin_oe_n_q,
  input wire receive_only_pin_in,
  // Port status
  output reg lsb_mode_q,
  output reg busy_q,
  output reg xfer_done_q,
  output reg xfer_abort_q,
  output reg overrun_q,
  // Core side
  output wire [`SHRP_BYTE_W-1:0] load_control_q,
  output wire device_register_wr_stb_q,
  output wire [`SHRP_ADDR_W-1:0] device_register_wr_addr_q,
  output wire [`SHRP_BYTE_W-1:0] device_register_wr_data_q,
  input wire [AW-1:0] core_ram_addr,
  output wire [`SHRP_BYTE_W-1:0] core_ram_data_q
);

  // ==========================================================
  // States
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_CMD = 4'h2;
  localparam [3:0] ST_DATA = 4'h4;
  localparam [3:0] ST_DONE = 4'h8;

  // ==========================================================
  // Bit-order helpers
  function [`SHRP_BYTE_W-1:0] shift_in;
    input [`SHRP_BYTE_W-1:0] value;
    input bit_in;
    input lsb_first;
    begin
      if (lsb_first) begin
        shift_in = {bit_in, value[7:1]};
      end else begin
        shift_in = {value[6:0], bit_in};
      end
    end
  endfunction

  function lead_bit;
    input [`SHRP_BYTE_W-1:0] value;
    input lsb_first;
    begin
      lead_bit = lsb_first ? value[0] : value[7];
    end
  endfunction

  // ==========================================================
  // Pin synchronisers
  wire [3:0] pin_lvl;
  wire sclk_lvl = pin_lvl[0];
  wire csn_lvl = pin_lvl[1];
  wire shared_lvl = pin_lvl[2];
  wire recv_lvl = pin_lvl[3];

  // Filter adds four cycles; each sclk phase must outlast it
  shrp_sync #(
    .WIDTH(4),
    .INIT(`SHRP_PIN_INIT)
  ) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .ce(ce),
    .async_in({receive_only_pin_in, shared_tx_rx_pin_in, cs_n, sclk}),
    .level_q(pin_lvl)
  );

  // History resets to idle pin levels, so no false edge after reset
  reg sclk_prev_q;
  reg csn_prev_q;
  wire sclk_rise = sclk_lvl && !sclk_prev_q;
  wire sclk_fall = !sclk_lvl && sclk_prev_q;
  wire cs_fall = !csn_lvl && csn_prev_q;
  wire cs_rise = csn_lvl && !csn_prev_q;

  // ==========================================================
  // Registers
  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [2:0] cnt_q;
  reg [2:0] cnt_d;
  reg lsb_mode_d;
  reg rw_read_q;
  reg rw_read_d;
  reg [`SHRP_ADDR_W-1:0] addr_q;
  reg [`SHRP_ADDR_W-1:0] addr_d;
  reg [`SHRP_BYTE_W-1:0] rx_q;
  reg [`SHRP_BYTE_W-1:0] rx_d;
  reg [`SHRP_BYTE_W-1:0] tx_q;
  reg [`SHRP_BYTE_W-1:0] tx_d;
  reg tx_loaded_q;
  reg tx_loaded_d;
  reg pin_out_d;
  reg pin_oe_n_d;
  reg wr_stb_q;
  reg wr_stb_d;
  reg [`SHRP_BYTE_W-1:0] wr_data_q;
  reg [`SHRP_BYTE_W-1:0] wr_data_d;
  reg done_d;
  reg abort_d;
  reg overrun_d;
  reg [`SHRP_BYTE_W-1:0] rx_next;

  // Store answers a cycle after decode, well ahead of the first fall
  wire [`SHRP_BYTE_W-1:0] rd_data;

  // Receive pin choice depends on the mode caught at select
  wire rx_bit = lsb_mode_q ? shared_lvl : recv_lvl;

  // ==========================================================
  // Transfer sequencer
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    lsb_mode_d = lsb_mode_q;
    rw_read_d = rw_read_q;
    addr_d = addr_q;
    rx_d = rx_q;
    tx_d = tx_q;
    tx_loaded_d = tx_loaded_q;
    pin_out_d = shared_tx_rx_pin_out_q;
    pin_oe_n_d = shared_tx_rx_pin_oe_n_q;
    wr_stb_d = 1'b0;
    wr_data_d = wr_data_q;
    done_d = 1'b0;
    abort_d = 1'b0;
    overrun_d = overrun_q;
    rx_next = shift_in(rx_q, rx_bit, lsb_mode_q);
    if (cs_rise) begin
      // Select high ends the session whatever its progress
      state_d = ST_IDLE;
      pin_oe_n_d = 1'b1;
      done_d = (state_q == ST_DONE);
      abort_d = (state_q == ST_CMD) || (state_q == ST_DATA);
    end else if (cs_fall) begin
      // Mode holds for the whole session
      lsb_mode_d = sclk_lvl;
      state_d = ST_CMD;
      cnt_d = 3'd0;
      rx_d = 8'h00;
      tx_loaded_d = 1'b0;
      pin_oe_n_d = 1'b1;
      overrun_d = 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          pin_oe_n_d = 1'b1;
        end
        ST_CMD: begin
          if (sclk_rise) begin
            rx_d = rx_next;
            cnt_d = cnt_q + 3'd1;
            if (cnt_q == 3'd7) begin
              // Decoded on the eighth rising edge, ahead of any data fall
              rw_read_d = (rx_next[`SHRP_RW_BIT] == `SHRP_RW_READ);
              addr_d = rx_next[`SHRP_ADDR_MSB:0];
              state_d = ST_DATA;
              cnt_d = 3'd0;
            end
          end
        end
        ST_DATA: begin
          if (sclk_rise) begin
            cnt_d = cnt_q + 3'd1;
            if (!rw_read_q) begin
              rx_d = rx_next;
            end
            // Reads never sample: receive pin is disregarded
            if (cnt_q == 3'd7) begin
              state_d = ST_DONE;
              if (!rw_read_q) begin
                wr_stb_d = 1'b1;
                wr_data_d = rx_next;
              end
            end
          end else if (sclk_fall && rw_read_q) begin
            pin_oe_n_d = 1'b0;
            if (!tx_loaded_q) begin
              pin_out_d = lead_bit(rd_data, lsb_mode_q);
              tx_d = shift_in(rd_data, 1'b0, lsb_mode_q);
              tx_loaded_d = 1'b1;
            end else begin
              pin_out_d = lead_bit(tx_q, lsb_mode_q);
              tx_d = shift_in(tx_q, 1'b0, lsb_mode_q);
            end
          end
        end
        ST_DONE: begin
          // Clocks past the second byte are ignored but reported
          if (sclk_rise) begin
            overrun_d = 1'b1;
          end
        end
        default: begin
          // Illegal code: back to idle with the pin released
          state_d = ST_IDLE;
          pin_oe_n_d = 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // State registers
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      cnt_q <= 3'd0;
      sclk_prev_q <= 1'b0;
      csn_prev_q <= 1'b1;
      lsb_mode_q <= 1'b0;
      rw_read_q <= 1'b0;
      addr_q <= 6'h00;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      tx_loaded_q <= 1'b0;
      shared_tx_rx_pin_out_q <= 1'b0;
      shared_tx_rx_pin_oe_n_q <= 1'b1;
      wr_stb_q <= 1'b0;
      wr_data_q <= 8'h00;
      busy_q <= 1'b0;
      xfer_done_q <= 1'b0;
      xfer_abort_q <= 1'b0;
      overrun_q <= 1'b0;
    end else if (ce) begin
      // Edge history freezes with the state, so no edge is lost
      state_q <= state_d;
      cnt_q <= cnt_d;
      sclk_prev_q <= sclk_lvl;
      csn_prev_q <= csn_lvl;
      lsb_mode_q <= lsb_mode_d;
      rw_read_q <= rw_read_d;
      addr_q <= addr_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      tx_loaded_q <= tx_loaded_d;
      shared_tx_rx_pin_out_q <= pin_out_d;
      shared_tx_rx_pin_oe_n_q <= pin_oe_n_d;
      wr_stb_q <= wr_stb_d;
      wr_data_q <= wr_data_d;
      busy_q <= (state_d != ST_IDLE);
      xfer_done_q <= done_d;
      xfer_abort_q <= abort_d;
      overrun_q <= overrun_d;
    end
  end

  // ==========================================================
  // Register file and boot RAM
  shrp_store #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_store (
    .core_clk(core_clk),
    .resetn(resetn),
    .ce(ce),
    .wr_stb(wr_stb_q),
    .addr(addr_q),
    .wr_data(wr_data_q),
    .rd_data_q(rd_data),
    .load_control_q(load_control_q),
    .device_register_wr_stb_q(device_register_wr_stb_q),
    .device_register_wr_addr_q(device_register_wr_addr_q),
    .device_register_wr_data_q(device_register_wr_data_q),
    .core_ram_addr(core_ram_addr),
    .core_ram_data_q(core_ram_data_q)
  );

endmodule // shrp_port

//--- core/shrp_store.v
`timescale 1ns/1ns
`include "shrp_defines.vh"

module shrp_store #(
  parameter DEPTH = `SHRP_BOOT_DEPTH,
  parameter AW = `SHRP_BOOT_AW
) (
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  input wire ce,
  // Access from the serial port
  input wire wr_stb,
  input wire [`SHRP_ADDR_W-1:0] addr,
  input wire [`SHRP_BYTE_W-1:0] wr_data,
  output reg [`SHRP_BYTE_W-1:0] rd_data_q,
  // Core side
  output reg [`SHRP_BYTE_W-1:0] load_control_q,
  output reg device_register_wr_stb_q,
  output reg [`SHRP_ADDR_W-1:0] device_register_wr_addr_q,
  output reg [`SHRP_BYTE_W-1:0] device_register_wr_data_q,
  input wire [AW-1:0] core_ram_addr,
  output reg [`SHRP_BYTE_W-1:0] core_ram_data_q
);

  reg [`SHRP_BYTE_W-1:0] device_register_mem [0:`SHRP_DEVICE_REGISTER_DEPTH-1];
  reg [`SHRP_BYTE_W-1:0] boot_program_ram [0:DEPTH-1];
  reg [AW-1:0] ram_ptr_q;
  reg [`SHRP_BYTE_W-1:0] sig_q;

  wire boot = load_control_q[`SHRP_CTL_BOOT_BIT];
  wire ctl_hit = (addr == `SHRP_CTL_ADDR);
  wire rom_mode = (wr_data[`SHRP_CTL_MODE_MSB:`SHRP_CTL_MODE_LSB] == `SHRP_CTL_MODE_ROM);

  // ==========================================================
  // Arrays: no reset so they map onto RAM
  always @(posedge core_clk) begin
    if (ce) begin
      if (wr_stb && boot && !ctl_hit) begin
        boot_program_ram[ram_ptr_q] <= wr_data;
      end
      if (wr_stb && !boot) begin
        device_register_mem[addr] <= wr_data;
      end
      core_ram_data_q <= boot_program_ram[core_ram_addr];
    end
  end

  // ==========================================================
  // Control, pointer, signature and read data
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      load_control_q <= `SHRP_CTL_RESET;
      ram_ptr_q <= {AW{1'b0}};
      sig_q <= `SHRP_SIG_SEED;
      rd_data_q <= 8'h00;
      device_register_wr_stb_q <= 1'b0;
      device_register_wr_addr_q <= 6'h00;
      device_register_wr_data_q <= 8'h00;
    end else if (ce) begin
      device_register_wr_stb_q <= wr_stb && !boot;
      if (wr_stb) begin
        device_register_wr_addr_q <= addr;
        device_register_wr_data_q <= wr_data;
        if (ctl_hit) begin
          load_control_q <= wr_data;
          if (rom_mode) begin
            ram_ptr_q <= {AW{1'b0}};
            sig_q <= `SHRP_SIG_SEED;
          end
        end else if (boot) begin
          ram_ptr_q <= ram_ptr_q + {{(AW-1){1'b0}}, 1'b1};
          sig_q <= {sig_q[6:0], sig_q[7]} ^ wr_data;
        end
      end
      // Boot mode reads only return control or signature
      if (boot) begin
        rd_data_q <= addr[`SHRP_RD_SIG_SEL_BIT] ? load_control_q : sig_q;
      end else if (ctl_hit) begin
        rd_data_q <= load_control_q;
      end else begin
        rd_data_q <= device_register_mem[addr];
      end
    end
  end

endmodule // shrp_store

//--- core/shrp_sync.v
`timescale 1ns/1ns
`include "shrp_defines.vh"

module shrp_sync #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] INIT = `SHRP_PIN_INIT
) (
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  input wire ce,
  // Asynchronous pins
  input wire [WIDTH-1:0] async_in,
  // Filtered levels
  output reg [WIDTH-1:0] level_q
);

  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;

  // ==========================================================
  // Three stages; level moves only when stages two and three agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          s1_q[i] <= INIT[i];
          s2_q[i] <= INIT[i];
          s3_q[i] <= INIT[i];
          level_q[i] <= INIT[i];
        end else if (ce) begin
          s1_q[i] <= async_in[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          if (s2_q[i] == s3_q[i]) begin
            level_q[i] <= s3_q[i];
          end
        end
      end
    end
  endgenerate

endmodule // shrp_sync

//--- testbench/shrp_host_model.sv
`timescale 1ns/1ns

module shrp_host_model (
  // Clock
  input wire core_clk,
  // Device side of the shared pin
  input wire dev_out,
  input wire dev_oe_n,
  // Link pins
  output reg sclk,
  output reg cs_n,
  output wire shared_pin,
  output wire recv_pin
);
  reg drv_en_q;
  reg drv_bit_q;
  reg lsb_q;
  reg junk_q;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    drv_en_q = 1'b0;
    drv_bit_q = 1'b0;
    lsb_q = 1'b0;
    junk_q = 1'b0;
  end
  always @(posedge core_clk) begin
    junk_q <= ~junk_q;
  end
  // Undriven lines toggle so a stale bit never passes as data
  assign shared_pin = !dev_oe_n ? dev_out : (drv_en_q && lsb_q) ? drv_bit_q : junk_q;
  assign recv_pin = (drv_en_q && !lsb_q) ? drv_bit_q : junk_q;

  // ==========================================================
  // One session of nbits clocks; sclk idles at the mode level
  task xfer(input lsb, input [7:0] cmd, input [7:0] wdata, input integer nbits, output [7:0] rdata);
    integer i;
    integer j;
    reg [7:0] byt;
    begin
      rdata = 8'h00;
      lsb_q <= lsb;
      sclk <= lsb;
      repeat (4) @(posedge core_clk);
      cs_n <= 1'b0;
      repeat (8) @(posedge core_clk);
      for (i = 0; i < nbits; i = i + 1) begin
        @(posedge core_clk);
        // Read bits taken late in the high phase, writes ignore the pin
        if (cmd[7] && i > 8 && i <= 16) rdata[lsb ? (i - 9) : (16 - i)] = shared_pin;
        j = i % 8;
        byt = (i < 8) ? cmd : wdata;
        sclk <= 1'b0;
        drv_bit_q <= byt[lsb ? j : 7 - j];
        drv_en_q <= (i < 8) || (!cmd[7] && i < 16);
        repeat (4) @(posedge core_clk);
        sclk <= 1'b1;
        repeat (3) @(posedge core_clk);
      end
      @(posedge core_clk);
      if (cmd[7] && nbits == 16) rdata[lsb ? 7 : 0] = shared_pin;
      drv_en_q <= 1'b0;
      sclk <= lsb;
      repeat (4) @(posedge core_clk);
      cs_n <= 1'b1;
      repeat (12) @(posedge core_clk);
    end
  endtask
endmodule // shrp_host_model

//--- testbench/shrp_port_assertions.sv
`timescale 1ns/1ns

module shrp_port_assertions (
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  input wire ce,
  // Link pins
  input wire sclk,
  input wire cs_n,
  input wire shared_tx_rx_pin_oe_n_q,
  // Status and core side
  input wire lsb_mode_q,
  input wire busy_q,
  input wire xfer_done_q,
  input wire xfer_abort_q,
  input wire overrun_q,
  input wire device_register_wr_stb_q
);
  // ==========================================================
  // Rising sclk edges since the last select fall, kept after select rises
  reg sclk_q;
  reg cs_n_q;
  reg [4:0] rise_cnt_q;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      rise_cnt_q <= 5'h00;
    end else begin
      sclk_q <= sclk;
      cs_n_q <= cs_n;
      if (cs_n_q && !cs_n) begin
        rise_cnt_q <= 5'h00;
      end else if (!cs_n && sclk && !sclk_q && rise_cnt_q != 5'h1f) begin
        rise_cnt_q <= rise_cnt_q + 5'h01;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  // Enable low freezes the port, so timing checks pause with it
  default disable iff (!resetn || !ce);

  // ==========================================================
  // Properties
  a_idle_pin_released: assert property (cs_n [*6] |-> shared_tx_rx_pin_oe_n_q)
    else $error("shared pin driven while deselected");
  a_drive_after_cmd: assert property (!shared_tx_rx_pin_oe_n_q && !cs_n |-> rise_cnt_q >= 5'h08)
    else $error("shared pin driven inside command byte");
  a_mode_at_select: assert property ($changed(lsb_mode_q) |-> !cs_n && (lsb_mode_q == sclk))
    else $error("mode does not follow sclk at select");
  a_done_full_pulse: assert property (xfer_done_q |-> rise_cnt_q >= 5'h10 ##1 !xfer_done_q)
    else $error("done without sixteen clocks or too long");
  a_abort_short_xfer: assert property (xfer_abort_q |-> rise_cnt_q < 5'h10 && !xfer_done_q)
    else $error("abort after a full transfer");
  a_overrun_cause: assert property ($rose(overrun_q) |-> rise_cnt_q > 5'h10)
    else $error("overrun without extra clocks");
  a_write_after_data: assert property (device_register_wr_stb_q |-> rise_cnt_q >= 5'h10 ##1 !device_register_wr_stb_q)
    else $error("register write before data byte");
  a_busy_opens: assert property ($fell(cs_n) |-> ##[2:8] busy_q)
    else $error("session not opened at select");
  a_busy_closes: assert property (cs_n [*8] |-> !busy_q)
    else $error("session left open after deselect");

  c_done: cover property (xfer_done_q);
  c_abort: cover property (xfer_abort_q);
  c_overrun: cover property ($rose(overrun_q));
  c_lsb_read: cover property (!shared_tx_rx_pin_oe_n_q && lsb_mode_q);
endmodule // shrp_port_assertions

bind shrp_port shrp_port_assertions u_chk (
  .core_clk,
  .resetn,
  .ce,
  .sclk,
  .cs_n,
  .shared_tx_rx_pin_oe_n_q,
  .lsb_mode_q,
  .busy_q,
  .xfer_done_q,
  .xfer_abort_q,
  .overrun_q,
  .device_register_wr_stb_q
);

//--- testbench/shrp_port_bench.sv
`timescale 1ns/1ns

module shrp_port_bench;
  reg core_clk;
  reg resetn;
  reg ce;
  reg [5:0] core_ram_addr;
  wire sclk;
  wire cs_n;
  wire shared_pin;
  wire recv_pin;
  wire pin_out;
  wire pin_oe_n;
  wire lsb_mode_q;
  wire busy_q;
  wire xfer_done_q;
  wire xfer_abort_q;
  wire overrun_q;
  wire [7:0] load_control_q;
  wire device_register_wr_stb_q;
  wire [5:0] device_register_wr_addr_q;
  wire [7:0] device_register_wr_data_q;
  wire [7:0] core_ram_data_q;
  integer errors;
  integer check_count;
  integer writes;
  integer aborts;
  integer dones;
  reg [5:0] wr_addr;
  reg [7:0] wr_data;

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  shrp_host_model host (.core_clk(core_clk), .dev_out(pin_out), .dev_oe_n(pin_oe_n), .sclk(sclk), .cs_n(cs_n),
    .shared_pin(shared_pin), .recv_pin(recv_pin));

  // Boot store shrunk to 64 bytes to keep elaboration light
  shrp_port #(.DEPTH(64), .AW(6)) dut (.core_clk(core_clk), .resetn(resetn), .ce(ce), .sclk(sclk), .cs_n(cs_n),
    .shared_tx_rx_pin_in(shared_pin), .shared_tx_rx_pin_out_q(pin_out), .shared_tx_rx_pin_oe_n_q(pin_oe_n),
    .receive_only_pin_in(recv_pin), .lsb_mode_q(lsb_mode_q), .busy_q(busy_q), .xfer_done_q(xfer_done_q),
    .xfer_abort_q(xfer_abort_q), .overrun_q(overrun_q), .load_control_q(load_control_q),
    .device_register_wr_stb_q(device_register_wr_stb_q), .device_register_wr_addr_q(device_register_wr_addr_q),
    .device_register_wr_data_q(device_register_wr_data_q),
    .core_ram_addr(core_ram_addr), .core_ram_data_q(core_ram_data_q));

  always @(posedge core_clk) begin
    if (device_register_wr_stb_q === 1'b1) begin
      writes = writes + 1;
      wr_addr = device_register_wr_addr_q;
      wr_data = device_register_wr_data_q;
    end
    if (xfer_abort_q === 1'b1) aborts = aborts + 1;
    if (xfer_done_q === 1'b1) dones = dones + 1;
  end

  task check(input [7:0] got, input [7:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task end_sim;
    begin
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask

  // ==========================================================
  // Scenarios
  task t_write(input lsb, input [7:0] cmd, input [7:0] d, input integer nbits, input integer exp_wr);
    integer n0;
    reg [7:0] r;
    begin
      n0 = writes;
      host.xfer(lsb, cmd, d, nbits, r);
      check({7'h00, lsb_mode_q}, {7'h00, lsb});
      check(8'(writes - n0), 8'(exp_wr));
      if (exp_wr == 1) check({2'b00, wr_addr}, {2'b00, cmd[5:0]});
      if (exp_wr == 1) check(wr_data, d);
      $display("test write %h ended", cmd);
    end
  endtask

  task t_read(input lsb, input [5:0] a, input [7:0] exp);
    integer n0;
    integer d0;
    reg [7:0] r;
    begin
      n0 = writes;
      d0 = dones;
      host.xfer(lsb, {2'b10, a}, 8'h00, 16, r);
      check(8'(dones - d0), 8'h01);
      check(r, exp);
      check(8'(writes - n0), 8'h00);
      $display("test read %h ended", a);
    end
  endtask

  task t_abort_overrun;
    integer a0;
    begin
      a0 = aborts;
      t_write(1'b0, 8'h05, 8'h77, 12, 0);
      check(8'(aborts - a0), 8'h01);
      t_write(1'b1, 8'h06, 8'h99, 18, 1);
      check({7'h00, overrun_q}, 8'h01);
      $display("test abort and overrun ended");
    end
  endtask

  task t_boot;
    integer k;
    reg [7:0] exp [0:2];
    begin
      exp[0] = 8'h11;
      exp[1] = 8'h22;
      exp[2] = 8'h33;
      t_write(1'b0, 8'h3f, 8'h04, 16, 1);
      check(load_control_q, 8'h04);
      t_write(1'b0, 8'h01, 8'h11, 16, 0);
      t_write(1'b1, 8'h02, 8'h22, 16, 0);
      t_write(1'b0, 8'h3f, 8'h04, 16, 0);
      t_write(1'b0, 8'h01, 8'h33, 16, 0);
      t_read(1'b1, 6'h20, 8'h04);
      for (k = 0; k < 3; k = k + 1) begin
        core_ram_addr <= k[5:0];
        repeat (2) @(posedge core_clk);
        check(core_ram_data_q, exp[k]);
      end
      t_write(1'b1, 8'h3f, 8'h00, 16, 0);
      check(load_control_q, 8'h00);
      $display("test boot load ended");
    end
  endtask

  // Enable low: a whole session must leave no trace
  task t_freeze;
    begin
      ce <= 1'b0;
      t_write(1'b1, 8'h2b, 8'h5a, 16, 0);
      ce <= 1'b1;
      check({7'h00, overrun_q}, 8'h01);
      check({7'h00, busy_q}, 8'h00);
      $display("test clock enable freeze ended");
    end
  endtask

  initial begin
    #200000;
    errors = errors + 1;
    end_sim;
  end

  initial begin
    errors = 0;
    check_count = 0;
    writes = 0;
    aborts = 0;
    dones = 0;
    wr_addr = 6'h00;
    wr_data = 8'h00;
    resetn = 1'b0;
    ce = 1'b1;
    core_ram_addr = 6'h00;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
    check(load_control_q, 8'h00);
    t_write(1'b0, 8'h15, 8'ha5, 16, 1);
    t_write(1'b1, 8'h2a, 8'h3c, 16, 1);
    t_read(1'b0, 6'h2a, 8'h3c);
    t_read(1'b1, 6'h15, 8'ha5);
    t_read(1'b0, 6'h3f, 8'h00);
    t_abort_overrun;
    t_freeze;
    t_boot;
    end_sim;
  end
endmodule // shrp_port_bench
